// file: design/urmfc_top.v
// register map and fifo control of one asynchronous serial channel
// assumes: host strobes wr_i/rd_i one cycle per access, shifters
// and baud logic sit outside and talk over the char ports
//
// What this block does
// - offset 2: writes configure fifos, reads identify
// - enable bit turns both fifos on
// - other fields change only with enable set
// - enable bit change empties both fifos
// - receive clear bit empties rx, self-clears
// - transmit clear bit empties tx, self-clears
// - mode bit selects ready signalling mode one
// - bits 7:6 pick trigger 1/4/8/14
// - bits 4 and 5 do nothing
// - bit 0 is lsb, first on line
// - legacy mode: fifo status bits read zero
// - format msb banks divisor at offsets 0/1
// - four interrupt enables, upper bits zero
// - identification bit 0 low when pending
// - fifo data interrupt follows trigger level
`timescale 1ns/1ns
`default_nettype none
`include "urmfc_defs.vh"
module urmfc_top #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  input  wire [2:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  input  wire [7:0]  rx_char_i,
  input  wire        rx_valid_i,
  input  wire [2:0]  rx_err_i,
  output reg  [7:0]  tx_char_o,
  output reg         tx_valid_o,
  input  wire        tx_take_i,
  input  wire        tx_idle_i,
  input  wire [3:0]  modem_i,
  output reg  [15:0] divisor_o,
  output reg  [7:0]  line_format_o,
  output reg  [5:0]  handshake_o,
  output reg         irq_o,
  output reg         receive_ready_out_n_o,
  output reg         transmit_ready_out_n_o
);
  // ==========================================
  // control state
  reg  [3:0]  ien_q;          // interrupt enables
  reg  [7:0]  spare_q;        // scratch byte
  reg         fifo_en_q;      // fifo enable
  reg         rdy_mode_q;     // ready signalling mode
  reg  [1:0]  trig_q;         // receive trigger select
  reg  [3:0]  lerr_q;         // break, framing, parity, overrun
  reg         fifo_err_q;     // error char entered rx fifo
  reg  [3:0]  mprev_q;        // previous modem inputs
  reg  [3:0]  mdelta_q;       // modem change flags
  reg         holding_empty_flag_int_q;     // holding empty interrupt
  reg         tx_empty_prev_q;// tx empty one cycle ago
  // ==========================================
  // decode
  wire        divsel;         // divisor access select
  wire        at_data;        // offset 0
  wire        at_ien;         // offset 1
  wire        wr_thold;       // write transmit holding
  wire        wr_fcfg;        // write fifo configuration
  wire        rd_rbuf;        // read receive buffer
  wire        rd_ident;       // read identification
  wire        rd_lstat;       // read line state
  wire        rd_hstat;       // read handshake state
  assign divsel  = line_format_o[`URMFC_LF_DIVSEL];
  assign at_data = (addr_i == `URMFC_OFS_DATA);
  assign at_ien  = (addr_i == `URMFC_OFS_IEN);
  assign wr_thold = wr_i & at_data & ~divsel;
  assign wr_fcfg  = wr_i & (addr_i == `URMFC_OFS_IDENT);
  assign rd_rbuf  = rd_i & at_data & ~divsel;
  assign rd_ident = rd_i & (addr_i == `URMFC_OFS_IDENT);
  assign rd_lstat = rd_i & (addr_i == `URMFC_OFS_LSTAT);
  assign rd_hstat = rd_i & (addr_i == `URMFC_OFS_HSTAT);
  // ==========================================
  // fifo clearing
  wire        en_change;      // write flips enable bit
  wire        rx_clr;         // empty receive fifo
  wire        tx_clr;         // empty transmit fifo
  assign en_change = wr_fcfg & (wdata_i[`URMFC_FC_EN] != fifo_en_q);
  // clear bits act only in a write with enable set
  assign rx_clr = en_change | (wr_fcfg & wdata_i[`URMFC_FC_EN]
                  & wdata_i[`URMFC_FC_RXCLR]);
  assign tx_clr = en_change | (wr_fcfg & wdata_i[`URMFC_FC_EN]
                  & wdata_i[`URMFC_FC_TXCLR]);
  // ==========================================
  // receive fifo
  wire [AW:0] rx_cnt;         // receive fill
  wire [7:0]  rx_head;        // oldest received char
  wire        rx_in_ready;    // room in receive fifo
  wire        rx_room;        // room given the mode
  wire        rx_push;        // char accepted
  wire        rx_overrun;     // char lost
  // legacy mode holds one char only
  assign rx_room = fifo_en_q | (rx_cnt == {(AW+1){1'b0}});
  assign rx_push = rx_valid_i & rx_room & rx_in_ready & ~rx_clr;
  assign rx_overrun = rx_valid_i & ~rx_push & ~rx_clr;
  urmfc_fifo #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_rx_fifo (
    .clk_i       (core_clk_i),
    .nrst_i      (nrst_i),
    .clr_i       (rx_clr),
    .in_valid_i  (rx_valid_i & rx_room),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (rx_char_i),
    .out_valid_o (),
    .out_ready_i (rd_rbuf),
    .out_data_o  (rx_head),
    .count_o     (rx_cnt)
  );
  // ==========================================
  // transmit fifo
  wire [AW:0] tx_cnt;         // transmit fill
  wire [7:0]  tx_head;        // oldest char to send
  wire        tx_in_ready;    // room in transmit fifo
  wire        tx_room;        // room given the mode
  wire        tx_head_valid;  // char waiting
  wire        tx_load;        // move char to shifter stage
  wire        tx_empty;       // holding side empty
  assign tx_room  = fifo_en_q | (tx_cnt == {(AW+1){1'b0}});
  assign tx_load  = tx_head_valid & (~tx_valid_o | tx_take_i);
  assign tx_empty = (tx_cnt == {(AW+1){1'b0}});
  urmfc_fifo #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_tx_fifo (
    .clk_i       (core_clk_i),
    .nrst_i      (nrst_i),
    .clr_i       (tx_clr),
    .in_valid_i  (wr_thold & tx_room),
    .in_ready_o  (tx_in_ready),
    .in_data_i   (wdata_i),
    .out_valid_o (tx_head_valid),
    .out_ready_i (tx_load),
    .out_data_o  (tx_head),
    .count_o     (tx_cnt)
  );
  // ==========================================
  // trigger level and interrupt sources
  reg  [4:0]  trig_lvl;       // trigger level in bytes
  wire        rx_trig;        // fill at or above trigger
  wire        p_line;         // line status pending
  wire        p_rdata;        // received data pending
  wire        p_holding_empty_flag;         // holding empty pending
  wire        p_modem;        // modem status pending
  wire        pending;        // any pending
  reg  [1:0]  int_id;         // highest priority id
  wire [7:0]  ident;          // identification byte
  wire [7:0]  lstat;          // line state byte
  // decode trigger select
  always @* begin
    case (trig_q)
      2'b00:   trig_lvl = `URMFC_TRIG_00;
      2'b01:   trig_lvl = `URMFC_TRIG_01;
      2'b10:   trig_lvl = `URMFC_TRIG_10;
      2'b11:   trig_lvl = `URMFC_TRIG_11;
      default: trig_lvl = `URMFC_TRIG_00;
    endcase
  end
  assign rx_trig = (rx_cnt >= {{(AW-4){1'b0}}, trig_lvl});
  assign p_line  = ien_q[2] & (|lerr_q);
  // level follows fill against trigger in fifo mode
  assign p_rdata = ien_q[0] & (fifo_en_q ? rx_trig
                   : (rx_cnt != {(AW+1){1'b0}}));
  assign p_holding_empty_flag  = ien_q[1] & holding_empty_flag_int_q;
  assign p_modem = ien_q[3] & (|mdelta_q);
  assign pending = p_line | p_rdata | p_holding_empty_flag | p_modem;
  // priority encode, line status highest
  always @* begin
    if (p_line) begin
      int_id = `URMFC_ID_LINE;
    end else if (p_rdata) begin
      int_id = `URMFC_ID_RDATA;
    end else if (p_holding_empty_flag) begin
      int_id = `URMFC_ID_HOLDING_EMPTY_FLAG;
    end else begin
      int_id = `URMFC_ID_MODEM;
    end
  end
  // fifo status bits zero in legacy mode, timeout bit zero
  assign ident = {fifo_en_q, fifo_en_q, 2'b00, 1'b0,
                  int_id, ~pending};
  assign lstat = {fifo_en_q & fifo_err_q,
                  tx_empty & ~tx_valid_o & tx_idle_i,
                  tx_empty, lerr_q[3], lerr_q[2], lerr_q[1],
                  lerr_q[0], (rx_cnt != {(AW+1){1'b0}})};
  // ==========================================
  // read data mux, registered
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `URMFC_RST_BYTE;
    end else if (rd_i) begin
      case (addr_i)
        `URMFC_OFS_DATA:  rdata_o <= divsel ? divisor_o[7:0]
                                     : rx_head;
        `URMFC_OFS_IEN:   rdata_o <= divsel ? divisor_o[15:8]
                                     : {4'h0, ien_q};
        `URMFC_OFS_IDENT: rdata_o <= ident;
        `URMFC_OFS_LFMT:  rdata_o <= line_format_o;
        `URMFC_OFS_HSCTL: rdata_o <= {2'b00, handshake_o};
        `URMFC_OFS_LSTAT: rdata_o <= lstat;
        `URMFC_OFS_HSTAT: rdata_o <= {modem_i, mdelta_q};
        default:          rdata_o <= spare_q;
      endcase
    end
  end
  // ==========================================
  // host written registers
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ien_q         <= 4'h0;
      line_format_o <= `URMFC_RST_BYTE;
      handshake_o   <= 6'h00;
      spare_q       <= `URMFC_RST_BYTE;
      divisor_o     <= `URMFC_RST_DIV;
    end else if (wr_i) begin
      case (addr_i)
        `URMFC_OFS_DATA: begin
          if (divsel) begin
            divisor_o[7:0] <= wdata_i;
          end
        end
        `URMFC_OFS_IEN: begin
          if (divsel) begin
            divisor_o[15:8] <= wdata_i;
          end else begin
            ien_q <= wdata_i[3:0];
          end
        end
        `URMFC_OFS_LFMT:  line_format_o <= wdata_i;
        `URMFC_OFS_HSCTL: handshake_o   <= wdata_i[5:0];
        `URMFC_OFS_SPARE: spare_q       <= wdata_i;
        default: begin
          // identification and status offsets hold nothing
        end
      endcase
    end
  end
  // ==========================================
  // fifo configuration, write only
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fifo_en_q  <= 1'b0;
      rdy_mode_q <= 1'b0;
      trig_q     <= 2'b00;
    end else if (wr_fcfg) begin
      fifo_en_q <= wdata_i[`URMFC_FC_EN];
      // bits 4 and 5 are dropped here
      if (wdata_i[`URMFC_FC_EN]) begin
        rdy_mode_q <= wdata_i[`URMFC_FC_MODE];
        trig_q     <= wdata_i[`URMFC_FC_TRIG_HI:`URMFC_FC_TRIG_LO];
      end
    end
  end
  // ==========================================
  // sticky line errors, set wins over read clear
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lerr_q     <= 4'h0;
      fifo_err_q <= 1'b0;
    end else begin
      lerr_q <= (rd_lstat ? 4'h0 : lerr_q)
                | {rx_push ? rx_err_i : 3'b000, rx_overrun};
      fifo_err_q <= (rd_lstat ? 1'b0 : fifo_err_q)
                    | (rx_push & (|rx_err_i));
    end
  end
  // ==========================================
  // modem change flags, ring counts on trailing edge
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mprev_q  <= 4'h0;
      mdelta_q <= 4'h0;
    end else begin
      mprev_q  <= modem_i;
      mdelta_q <= (rd_hstat ? 4'h0 : mdelta_q)
                  | {modem_i[3] ^ mprev_q[3],
                     mprev_q[2] & ~modem_i[2],
                     modem_i[1:0] ^ mprev_q[1:0]};
    end
  end
  // ==========================================
  // holding empty interrupt: set on going empty or
  // on enable, cleared by holding write or ident read
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      holding_empty_flag_int_q      <= 1'b0;
      tx_empty_prev_q <= 1'b1;
    end else begin
      tx_empty_prev_q <= tx_empty;
      if ((tx_empty & ~tx_empty_prev_q)
          | (wr_i & at_ien & ~divsel & wdata_i[1] & ~ien_q[1]
             & tx_empty)) begin
        holding_empty_flag_int_q <= 1'b1;
      end else if (wr_thold
                   | (rd_ident & ~p_line & ~p_rdata & p_holding_empty_flag)) begin
        holding_empty_flag_int_q <= 1'b0;
      end
    end
  end
  // ==========================================
  // shifter stage, untouched by fifo clears
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_valid_o <= 1'b0;
      tx_char_o  <= `URMFC_RST_BYTE;
    end else if (tx_load) begin
      tx_valid_o <= 1'b1;
      tx_char_o  <= tx_head;
    end else if (tx_take_i) begin
      tx_valid_o <= 1'b0;
    end
  end
  // ==========================================
  // ready pins and interrupt pin, active low readies
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_ready_out_n_o  <= `URMFC_RST_RDY_N;
      transmit_ready_out_n_o <= `URMFC_RST_RDY_N;
      irq_o                  <= 1'b0;
    end else begin
      irq_o <= pending & handshake_o[`URMFC_HC_INTEN];
      if (fifo_en_q & rdy_mode_q) begin
        receive_ready_out_n_o  <= ~rx_trig;
        transmit_ready_out_n_o <= ~tx_in_ready;
      end else begin
        receive_ready_out_n_o  <= (rx_cnt == {(AW+1){1'b0}});
        transmit_ready_out_n_o <= ~tx_empty;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/urmfc_defs.vh
// constants for the serial channel register map and fifo control
// assumes: included by urmfc_top by bare name, no code inside
`ifndef URMFC_DEFS_VH
`define URMFC_DEFS_VH
// ==========================================
// register offsets
`define URMFC_OFS_DATA   3'h0
`define URMFC_OFS_IEN    3'h1
`define URMFC_OFS_IDENT  3'h2
`define URMFC_OFS_LFMT   3'h3
`define URMFC_OFS_HSCTL  3'h4
`define URMFC_OFS_LSTAT  3'h5
`define URMFC_OFS_HSTAT  3'h6
`define URMFC_OFS_SPARE  3'h7
// ==========================================
// fifo configuration bit positions
`define URMFC_FC_EN      0
`define URMFC_FC_RXCLR   1
`define URMFC_FC_TXCLR   2
`define URMFC_FC_MODE    3
`define URMFC_FC_TRIG_LO 6
`define URMFC_FC_TRIG_HI 7
// line format: divisor access select bit
`define URMFC_LF_DIVSEL  7
// handshake control: interrupt pin enable bit
`define URMFC_HC_INTEN   3
// ==========================================
// receive trigger levels in bytes
`define URMFC_TRIG_00    5'h01
`define URMFC_TRIG_01    5'h04
`define URMFC_TRIG_10    5'h08
`define URMFC_TRIG_11    5'h0e
// ==========================================
// interrupt identification codes, bits 2:1
`define URMFC_ID_LINE    2'h3
`define URMFC_ID_RDATA   2'h2
`define URMFC_ID_HOLDING_EMPTY_FLAG    2'h1
`define URMFC_ID_MODEM   2'h0
// ==========================================
// reset values
`define URMFC_RST_BYTE   8'h00
`define URMFC_RST_DIV    16'h0000
`define URMFC_RST_RDY_N  1'b1
`endif

// file: design/urmfc_fifo.v
// synchronous fifo with count, clear and valid/ready on both ends
// assumes: one clock, DEPTH equal to two to the power AW
`timescale 1ns/1ns
`default_nettype none
module urmfc_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clk_i,
  input  wire          nrst_i,
  input  wire          clr_i,
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [W-1:0]  in_data_i,
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [W-1:0]  out_data_o,
  output reg  [AW:0]   count_o
);
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];  // count when full
  reg [W-1:0]  mem [0:DEPTH-1];              // storage array
  reg [AW-1:0] wr_ptr_q;                     // write pointer
  reg [AW-1:0] rd_ptr_q;                     // read pointer
  wire         push;                         // accepted write
  wire         pop;                          // accepted read
  assign in_ready_o  = (count_o != FULL_CNT);
  assign out_valid_o = (count_o != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr_q];
  assign push = in_valid_i & in_ready_o & ~clr_i;
  assign pop  = out_ready_i & out_valid_o & ~clr_i;
  // ==========================================
  // storage write, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end
  // pointers and count, clear wins over traffic
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_o  <= {(AW+1){1'b0}};
    end else if (clr_i) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_o  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_o <= count_o + 1'b1;
      end else if (pop & ~push) begin
        count_o <= count_o - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/urmfc_chk_sva.sv
// checker for the serial channel register map and fifo control
// assumes: bound to urmfc_top, one clock, async active low reset
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// checker module
module urmfc_chk (
  input wire        core_clk_i,
  input wire        nrst_i,
  input wire [2:0]  addr_i,
  input wire [7:0]  wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [7:0]  rdata_o,
  input wire        rx_valid_i,
  input wire [7:0]  tx_char_o,
  input wire        tx_valid_o,
  input wire        tx_take_i,
  input wire [15:0] divisor_o,
  input wire [7:0]  line_format_o,
  input wire        transmit_ready_out_n_o,
  input wire        receive_ready_out_n_o
);
  reg  fen_q;                                // enable bit as last written
  wire hold_wr = wr_i && addr_i == 3'h0;     // holding or divisor write
  wire id_rd   = rd_i && addr_i == 3'h2;     // identification read
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // follow the fifo enable bit from host writes
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fen_q <= 1'b0;
    end else if (wr_i && addr_i == 3'h2) begin
      fen_q <= wdata_i[0];
    end
  end
  // ==========================================
  // assertions
  a_ident_unused: assert property (id_rd |=> rdata_o[5:4] == 2'h0)
    else $error("ident unused bits not zero");
  a_ident_fifo_on: assert property (id_rd && fen_q |=>
    rdata_o[7:6] == 2'h3) else $error("fifo enabled bits not set");
  a_ident_legacy: assert property (id_rd && !fen_q |=>
    rdata_o[7:6] == 2'h0 && !rdata_o[3]) else $error("legacy ident bits");
  a_lstat_legacy: assert property (rd_i && addr_i == 3'h5 && !fen_q
    |=> !rdata_o[7]) else $error("legacy fifo error bit set");
  a_ien_upper: assert property (rd_i && addr_i == 3'h1 &&
    !line_format_o[7] |=> rdata_o[7:4] == 4'h0) else $error("ien upper bits");
  a_div_low: assert property (hold_wr && line_format_o[7] |=>
    divisor_o[7:0] == $past(wdata_i)) else $error("divisor low byte");
  a_div_high: assert property (wr_i && addr_i == 3'h1 &&
    line_format_o[7] |=> divisor_o[15:8] == $past(wdata_i))
    else $error("divisor high byte");
  a_tx_char_hold: assert property (tx_valid_o && !tx_take_i |=>
    tx_valid_o && $stable(tx_char_o)) else $error("tx char not held");
  a_rx_clear: assert property (wr_i && addr_i == 3'h2 &&
    wdata_i[1:0] == 2'h3 ##1 !rx_valid_i [*2] |-> ##[0:1]
    receive_ready_out_n_o) else $error("rx clear left data");
  a_tx_clear: assert property (wr_i && addr_i == 3'h2 &&
    wdata_i[0] && wdata_i[2] ##1 !hold_wr [*2] |-> ##[0:1]
    !transmit_ready_out_n_o) else $error("tx clear left data");
endmodule
bind urmfc_top urmfc_chk urmfc_chk_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rx_valid_i(rx_valid_i), .tx_char_o(tx_char_o),
  .tx_valid_o(tx_valid_o), .tx_take_i(tx_take_i),
  .divisor_o(divisor_o), .line_format_o(line_format_o),
  .transmit_ready_out_n_o(transmit_ready_out_n_o),
  .receive_ready_out_n_o(receive_ready_out_n_o)
);
`default_nettype wire

// file: tb/urmfc_host.sv
// host processor model on the byte-wide register port
// assumes: one strobe cycle per access, read data one cycle later
`timescale 1ns/1ns
`default_nettype none
module urmfc_host (
  input  wire             clk_i,
  input  wire       [7:0] rdata_i,
  output var logic  [2:0] addr_o,
  output var logic  [7:0] wdata_o,
  output var logic        wr_o,
  output var logic        rd_o
);
  // ==========================================
  // idle bus at time zero
  initial begin
    addr_o = 3'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // ==========================================
  // write: launched after an edge, taken at the next
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    // fifo fields always sent with the enable bit
    wdata_o <= (a == 3'h2 && d[7:1] != 7'h00) ? (d | 8'h01) : d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;  // stale data not left on the bus
  endtask
  // read: strobe one cycle, data taken one cycle later
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: tb/urmfc_tb.sv
// self-checking bench for the register map and fifo control
// assumes: urmfc_top, urmfc_host and the bound checker compiled
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {
    logic [2:0] a;  // offset
    logic       w;  // write before the read
    logic [7:0] d;  // write data
    logic [7:0] e;  // expected read data
  } urmfc_row_t;
  logic clk = 1'b0, nrst = 1'b0, rx_valid = 1'b0, tx_take = 1'b0;
  logic [7:0] rx_char = 8'h00;
  logic [2:0] rx_err = 3'h0;
  wire [2:0] addr;
  wire [7:0] wdata, rdata, tx_char, lfmt;
  wire wr, rd, tx_valid, irq, rrdy_n, trdy_n;
  wire [15:0] divisor;
  wire [5:0] hsk;
  int n_fail = 0;
  int tests_run = 0;
  // plain accesses: reset values, read-back, fixed zero bits
  urmfc_row_t rows [0:6] = '{'{3'h2, 1'b0, 8'h00, 8'h01},
    '{3'h7, 1'b0, 8'h00, 8'h00}, '{3'h7, 1'b1, 8'ha5, 8'ha5},
    '{3'h3, 1'b1, 8'h1b, 8'h1b}, '{3'h4, 1'b1, 8'he7, 8'h27},
    '{3'h1, 1'b1, 8'hf0, 8'h00}, '{3'h5, 1'b1, 8'hff, 8'h60}};
  always #2 clk = ~clk;
  urmfc_host urmfc_host_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  urmfc_top urmfc_top_i (.core_clk_i(clk), .nrst_i(nrst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .rx_char_i(rx_char), .rx_valid_i(rx_valid), .rx_err_i(rx_err),
    .tx_char_o(tx_char), .tx_valid_o(tx_valid), .tx_take_i(tx_take),
    .tx_idle_i(1'b1), .modem_i(4'h0), .divisor_o(divisor),
    .line_format_o(lfmt), .handshake_o(hsk), .irq_o(irq),
    .receive_ready_out_n_o(rrdy_n), .transmit_ready_out_n_o(trdy_n));
  // ==========================================
  // helpers
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one received char, line data inverted once released
  task push(input logic [7:0] c, input logic [2:0] e);
    @(posedge clk);
    rx_char <= c;
    rx_err <= e;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog: whole run is a few hundred cycles
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] d;
    int lv [4];
    lv = '{1, 4, 8, 14};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        urmfc_host_i.wr_reg(rows[i].a, rows[i].d);
      end
      urmfc_host_i.rd_reg(rows[i].a, d);
      chk(d, rows[i].e);
    end
    chk({hsk, lfmt}, {6'h27, 8'h1b});
    $display("test registers done");
    // banked divisor bytes
    urmfc_host_i.wr_reg(3'h3, 8'h80);
    urmfc_host_i.wr_reg(3'h0, 8'h34);
    urmfc_host_i.wr_reg(3'h1, 8'h12);
    wait_n(1);
    chk(divisor, 16'h1234);
    urmfc_host_i.rd_reg(3'h1, d);
    chk(d, 8'h12);
    urmfc_host_i.wr_reg(3'h3, 8'h03);
    $display("test divisor done");
    // legacy mode: parity error char, no fifo error bit
    push(8'h5a, 3'b001);
    urmfc_host_i.rd_reg(3'h5, d);
    chk({d[7], d[2], d[0]}, 3'b011);
    urmfc_host_i.rd_reg(3'h0, d);
    chk(d, 8'h5a);
    urmfc_host_i.wr_reg(3'h2, 8'h01);
    urmfc_host_i.rd_reg(3'h2, d);
    chk(d, 8'hc1);
    $display("test legacy done");
    // every trigger code in mode one, reserved bits on odd codes
    urmfc_host_i.wr_reg(3'h1, 8'h01);
    urmfc_host_i.wr_reg(3'h4, 8'h08);
    for (int k = 0; k < 4; k++) begin
      urmfc_host_i.wr_reg(3'h2, {k[1:0], k[0], k[0], 4'hb});
      for (int n = 1; n <= 14; n++) begin
        push(8'(n), 3'b000);
        wait_n(4);
        chk(rrdy_n, n < lv[k]);
        chk(irq, n >= lv[k]);
      end
      // data interrupt pending: bit 0 low, id data, fifo bits set
      urmfc_host_i.rd_reg(3'h2, d);
      chk(d, 8'hc4);
    end
    $display("test trigger done");
    // dropping the enable bit empties the fifos
    urmfc_host_i.wr_reg(3'h2, 8'h00);
    wait_n(4);
    chk({rrdy_n, irq}, 2'b10);
    urmfc_host_i.rd_reg(3'h5, d);
    chk(d[0], 1'b0);
    $display("test disable done");
    // sixteen chars fit, the seventeenth overruns
    urmfc_host_i.wr_reg(3'h2, 8'h01);
    for (int i = 0; i < 17; i++) push(8'(i), 3'b000);
    urmfc_host_i.rd_reg(3'h5, d);
    chk(d[1:0], 2'b11);
    for (int i = 0; i < 16; i++) begin
      urmfc_host_i.rd_reg(3'h0, d);
      chk(d, 8'(i));
    end
    urmfc_host_i.rd_reg(3'h5, d);
    chk(d[0], 1'b0);
    $display("test capacity done");
    // tx clear with the shifter stalled keeps the staged char
    urmfc_host_i.wr_reg(3'h0, 8'ha1);
    urmfc_host_i.wr_reg(3'h0, 8'hb2);
    urmfc_host_i.wr_reg(3'h0, 8'hc3);
    wait_n(3);
    chk({trdy_n, tx_valid, tx_char}, 10'h3a1);
    urmfc_host_i.wr_reg(3'h2, 8'h05);
    wait_n(3);
    chk({trdy_n, tx_valid, tx_char}, 10'h1a1);
    @(posedge clk);
    tx_take <= 1'b1;
    @(posedge clk);
    tx_take <= 1'b0;
    wait_n(3);
    chk(tx_valid, 1'b0);
    $display("test tx clear done");
    // rx clear empties the receive side
    push(8'h11, 3'b000);
    push(8'h22, 3'b000);
    wait_n(3);
    chk(rrdy_n, 1'b0);
    urmfc_host_i.wr_reg(3'h2, 8'h03);
    wait_n(3);
    chk(rrdy_n, 1'b1);
    urmfc_host_i.rd_reg(3'h5, d);
    chk(d[0], 1'b0);
    $display("test rx clear done");
    summarize();
  end
endmodule
`default_nettype wire
